// [pas_defines.svh]
// Offsets, field positions, reset values and timing counts of the autoneg status/id slice
`ifndef PAS_DEFINES_SVH
`define PAS_DEFINES_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define PAS_OFF_STATUS 5'h01
`define PAS_OFF_ID_HIGH 5'h02
`define PAS_OFF_ID_LOW 5'h03
`define PAS_OFF_ADVERT 5'h04
`define PAS_OFF_PARTNER 5'h05

// ************************************************************
// Status field positions
// ************************************************************
`define PAS_ST_PREAMBLE_SUPP 6
`define PAS_ST_AN_DONE 5
`define PAS_ST_REMOTE_FAULT 4
`define PAS_ST_AN_ABLE 3
`define PAS_ST_LINK 2
`define PAS_ST_JABBER 1
`define PAS_ST_EXT_CAP 0

// ************************************************************
// Advertisement layout and reset value, partner reset value
// ************************************************************
`define PAS_ADV_WR_MASK 16'hADE0
`define PAS_ADV_RESET 16'h0DE0
`define PAS_ADV_SELECTOR 5'h01
`define PAS_PARTNER_RESET 16'h0000

// ************************************************************
// Identifier fields and strap settling
// ************************************************************
`define PAS_OUI_HIGH 16'h1234
`define PAS_OUI_LOW6 6'h15
`define PAS_STRAP_SETTLE 2'h3

`endif

// [pas_latch_bit.sv]
// One latching status bit that clears back to the live condition on read
`timescale 1ns/1ps
`include "pas_defines.svh"

module pas_latch_bit #(
    parameter bit LATCH_LOW = 1'b0
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic sw_reset,
    input wire logic live,
    input wire logic read_clr,
    output logic flag
);
    // ************************************************************
    // Latch
    // ************************************************************
    // Live term enters in every cycle except a soft reset, so an event on the read cycle survives
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag <= 1'b0;
        end else if (sw_reset) begin
            flag <= 1'b0;
        end else if (read_clr) begin
            flag <= live;
        end else if (LATCH_LOW) begin
            flag <= flag & live;
        end else begin
            flag <= flag | live;
        end
    end

endmodule // pas_latch_bit

// [pas_mgmt_model.sv]
// Station management model that issues register reads and writes to the slice
`timescale 1ns/1ps
module pas_mgmt_model
    import pas_pkg::*;
(
    input wire logic ref_clk,
    output pas_req_t req,
    input wire logic [15:0] rd_data,
    input wire logic rd_valid
);
    // Idle bus at time zero
    initial begin
        req = '0;
    end

    // One write: strobe is a one-cycle pulse, launched off the falling edge
    task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
        @(negedge ref_clk);
        req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(negedge ref_clk);
        // Released lines carry junk so stale data is never mistaken for valid
        req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
    endtask

    // One read; the answer is due exactly one cycle after the strobe, else unknowns fail the compare
    task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
        @(negedge ref_clk);
        req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 16'hA5A5};
        @(negedge ref_clk);
        req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 16'h5A5A};
        d = (rd_valid === 1'b1) ? rd_data : 16'hXXXX;
    endtask
endmodule // pas_mgmt_model

// [pas_pkg.sv]
// Types shared by the autoneg status/id register slice
package pas_pkg;

    // Register access request from the management frame engine
    typedef struct packed {
        logic [4:0] addr;
        logic wr;
        logic rd;
        logic [15:0] wdata;
    } pas_req_t;

    // Live conditions from the negotiation and line logic
    typedef struct packed {
        logic an_complete;
        logic remote_fault;
        logic link_up;
        logic jabber;
    } pas_live_t;

    // Decoded register selection
    typedef enum logic [2:0] {
        PAS_SEL_NONE,
        PAS_SEL_STATUS,
        PAS_SEL_ID_HIGH,
        PAS_SEL_ID_LOW,
        PAS_SEL_ADVERT,
        PAS_SEL_PARTNER
    } pas_sel_t;

endpackage

// [pas_regs.sv]
// Status, identifier, advertisement and partner ability registers of the PHY management slice
`timescale 1ns/1ps
`include "pas_defines.svh"

// Summary of operation
// R1: Status bit 6 always reads one: preamble-less management frames accepted.
// R2: Status bit 5 shows negotiation finished; both resets clear it.
// R3: Status bit 4 latches high on remote fault until read; resets clear.
// R4: Status bit 2 latches low on link loss until read.
// R5: Status bit 1 latches high on jabber until read; resets to zero.
// R6: Status bits 3 and 0 are constant ones, unaffected by writes.
// R7: First identifier register is read-only, identifier bits 3 to 18.
// R8: Second identifier: identifier bits 19 to 24, then model and revision straps.
// R9: Advertisement writes read back at once, take effect on qualifying events.
// R10: Advertisement bit 11 asymmetric pause, read/write, resets to one.
// R11: Advertisement bit 10 pause, read/write, resets to one.
// R12: Advertisement bits 8 to 5 duplex/speed flags, read/write, reset one.
// R13: Advertisement bit 13 remote fault request, read/write, resets zero.
// R14: Advertisement bits 14, 12 and 9 always read zero.
// R15: Advertisement selector bits 4 to 0 fixed at 00001.
// R16: Partner bit 14 mirrors received acknowledge; resets zero.
// R17: Partner bit 13 mirrors received remote fault; resets zero.
// R18: Partner bits 12 to 10 mirror received bits; reset zero.
// R19: Partner bits 9 to 5 mirror received technology bits; reset zero.
// R20: Partner bits 4 to 0 hold received selector; reset zero.
// R21: Latched fields hold until read or reset, then follow live state.
// R22: Software trusts partner contents only after negotiation complete is set.
// R23: Effective advertisement copy loads on events; transmit pages use only it.
module pas_regs
    import pas_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire pas_req_t req,
    output logic [15:0] rd_data,
    output logic rd_valid,
    input wire pas_live_t live,
    input wire logic sw_reset,
    input wire logic an_restart,
    input wire logic power_down,
    input wire logic page_valid,
    input wire logic [15:0] page_word,
    input wire logic [5:0] model_number_straps,
    input wire logic [3:0] revision_number_straps,
    output logic [15:0] adv_effective
);

    // ************************************************************
    // Address decode
    // ************************************************************
    // Used for both read and write paths
    function automatic pas_sel_t decode(input logic [4:0] addr);
        pas_sel_t sel;
        sel = PAS_SEL_NONE;
        if (addr == `PAS_OFF_STATUS) begin
            sel = PAS_SEL_STATUS;
        end else if (addr == `PAS_OFF_ID_HIGH) begin
            sel = PAS_SEL_ID_HIGH;
        end else if (addr == `PAS_OFF_ID_LOW) begin
            sel = PAS_SEL_ID_LOW;
        end else if (addr == `PAS_OFF_ADVERT) begin
            sel = PAS_SEL_ADVERT;
        end else if (addr == `PAS_OFF_PARTNER) begin
            sel = PAS_SEL_PARTNER;
        end
        return sel;
    endfunction

    pas_sel_t sel;
    logic stat_rd;
    logic adv_wr;
    logic [15:0] adv_reg;
    logic [15:0] next_adv;
    logic [15:0] partner;
    logic an_done;
    logic [2:0] lat_live;
    logic [2:0] lat_flag;
    logic link_prev;
    logic pd_prev;
    logic load_eff;
    logic [9:0] strap_sync1;
    logic [9:0] strap_sync2;
    logic [9:0] strap_val;
    logic [1:0] settle_cnt;
    logic [15:0] status_word;
    logic [15:0] next_rd;

    // Strobes qualified by the decoded offset
    assign sel = decode(req.addr);
    assign stat_rd = req.rd && (sel == PAS_SEL_STATUS);
    assign adv_wr = req.wr && (sel == PAS_SEL_ADVERT);

    // ************************************************************
    // Strap capture
    // ************************************************************
    // Straps are pins, so two flops before anything looks at them
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_sync1 <= 10'h000;
            strap_sync2 <= 10'h000;
        end else begin
            strap_sync1 <= {model_number_straps, revision_number_straps};
            strap_sync2 <= strap_sync1;
        end
    end

    // Caught once after release; later strap wiggles are ignored
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            settle_cnt <= 2'h0;
            strap_val <= 10'h000;
        end else if (settle_cnt != `PAS_STRAP_SETTLE) begin
            settle_cnt <= settle_cnt + 2'h1;
            strap_val <= strap_sync2; // see R8
        end
    end

    // ************************************************************
    // Status bits
    // ************************************************************
    // Negotiation done tracks the engine, cleared by either reset
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            an_done <= 1'b0;
        end else if (sw_reset) begin
            an_done <= 1'b0;
        end else begin
            an_done <= live.an_complete; // see R2
        end
    end

    // Index 0 jabber, 1 link, 2 remote fault
    assign lat_live = {live.remote_fault, live.link_up, live.jabber};

    // Latched bits, only the link bit latches low
    generate
        for (genvar i = 0; i < 3; i++) begin : g_latch
            pas_latch_bit #(
                .LATCH_LOW(i == 1)
            ) u_latch (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .sw_reset(sw_reset),
                .live(lat_live[i]),
                .read_clr(stat_rd), // see R21
                .flag(lat_flag[i]) // see R3
            );
        end
    endgenerate

    // Upper capability bits live in another slice and read zero here
    always_comb begin
        status_word = 16'h0000;
        status_word[`PAS_ST_PREAMBLE_SUPP] = 1'b1; // see R1
        status_word[`PAS_ST_AN_DONE] = an_done;
        status_word[`PAS_ST_REMOTE_FAULT] = lat_flag[2]; // see R3
        status_word[`PAS_ST_AN_ABLE] = 1'b1; // see R6
        status_word[`PAS_ST_LINK] = lat_flag[1]; // see R4
        status_word[`PAS_ST_JABBER] = lat_flag[0]; // see R5
        status_word[`PAS_ST_EXT_CAP] = 1'b1; // see R6
    end

    // ************************************************************
    // Advertisement
    // ************************************************************
    // Only writable positions take data; fixed fields are reinserted
    always_comb begin
        next_adv = adv_reg;
        if (adv_wr) begin
            next_adv = (req.wdata & `PAS_ADV_WR_MASK) | (adv_reg & ~`PAS_ADV_WR_MASK); // see R9
        end
        next_adv[14] = 1'b0; // see R14
        next_adv[12] = 1'b0;
        next_adv[9] = 1'b0;
        next_adv[4:0] = `PAS_ADV_SELECTOR; // see R15
    end

    // Software reset keeps the written value so it can take effect
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            adv_reg <= `PAS_ADV_RESET | {11'h000, `PAS_ADV_SELECTOR}; // see R10, R11, R13
        end else begin
            adv_reg <= next_adv; // see R12
        end
    end

    // Edge history for power-down exit and link loss
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            link_prev <= 1'b0;
            pd_prev <= 1'b0;
        end else begin
            link_prev <= live.link_up;
            pd_prev <= power_down;
        end
    end

    // Power-down and link use falling edges only: a level would reload the copy on every idle cycle
    assign load_eff = sw_reset || an_restart || (pd_prev && !power_down) || (link_prev && !live.link_up);

    // Transmitter sees only this copy, so a half-written set never leaks out
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            adv_effective <= `PAS_ADV_RESET | {11'h000, `PAS_ADV_SELECTOR};
        end else if (load_eff) begin
            adv_effective <= next_adv; // see R23
        end
    end

    // ************************************************************
    // Partner ability
    // ************************************************************
    // Base page bits 14 to 0 are mirrored, bit 15 reads zero; valid only once negotiation is done
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            partner <= `PAS_PARTNER_RESET;
        end else if (sw_reset) begin
            partner <= `PAS_PARTNER_RESET; // see R20
        end else if (page_valid) begin
            partner <= {1'b0, page_word[14:0]}; // see R16, R18, R19
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    // Unmapped offsets answer zero
    always_comb begin
        next_rd = 16'h0000;
        if (sel == PAS_SEL_STATUS) begin
            next_rd = status_word;
        end else if (sel == PAS_SEL_ID_HIGH) begin
            next_rd = `PAS_OUI_HIGH; // see R7
        end else if (sel == PAS_SEL_ID_LOW) begin
            next_rd = {`PAS_OUI_LOW6, strap_val}; // see R8
        end else if (sel == PAS_SEL_ADVERT) begin
            next_rd = adv_reg;
        end else if (sel == PAS_SEL_PARTNER) begin
            next_rd = partner; // see R17
        end
    end

    // Data registered; valid is a one-cycle pulse beside it
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 16'h0000;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= req.rd;
            if (req.rd) begin
                rd_data <= next_rd;
            end
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    // All checks run on the core clock and sleep through hardware reset
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // Status word constants and latches, identifier low word
    status_const_a: assert property (stat_rd |=> rd_valid && rd_data[6] && rd_data[3] && rd_data[0]) // see R1
        else $error("status constant bits not one");
    an_done_a: assert property (sw_reset |=> !an_done) // see R2
        else $error("negotiation done not cleared by soft reset");
    rfault_hold_a: assert property (lat_flag[2] && !stat_rd && !sw_reset |=> lat_flag[2]) // see R3
        else $error("remote fault latch dropped before read");
    rfault_set_a: assert property (live.remote_fault && !sw_reset |=> lat_flag[2]) // see R3
        else $error("remote fault latch not set");
    link_low_a: assert property (!live.link_up || (!lat_flag[1] && !stat_rd) |=> !lat_flag[1]) // see R4
        else $error("link latch not held low");
    jabber_set_a: assert property (live.jabber && !sw_reset |=> lat_flag[0] ##1 // see R5
        (lat_flag[0] || $past(stat_rd) || $past(sw_reset)))
        else $error("jabber latch not set");
    id_low_a: assert property (req.rd && sel == PAS_SEL_ID_LOW |=> rd_data == {`PAS_OUI_LOW6, strap_val}) // see R8
        else $error("identifier low word wrong");

    // Advertisement readback, deferral and fixed fields; partner clear on soft reset
    adv_readback_a: assert property (adv_wr ##1 !adv_wr ##1 req.rd && sel == PAS_SEL_ADVERT // see R9
        |=> rd_data[15:5] == ($past(req.wdata[15:5], 3) & 11'h56F))
        else $error("advertisement write not read back");
    adv_defer_a: assert property (!load_eff |=> $stable(adv_effective)) // see R23
        else $error("effective advertisement changed without event");
    adv_fixed_a: assert property ( // see R14
        req.rd && sel == PAS_SEL_ADVERT |=> rd_data[4:0] == 5'h01 && !rd_data[14] && !rd_data[12] && !rd_data[9])
        else $error("advertisement fixed fields wrong");
    partner_clr_a: assert property (sw_reset |=> partner == 16'h0000) // see R20
        else $error("partner ability not cleared");

    // Identifier high word is a fixed constant
    id_high_a: assert property (req.rd && sel == PAS_SEL_ID_HIGH |=> rd_data == `PAS_OUI_HIGH) // see R7
        else $error("identifier high word wrong");

    // Each writable advertisement field takes the written bit in the next cycle
    asym_pause_a: assert property (adv_wr |=> adv_reg[11] == $past(req.wdata[11])) // see R10
        else $error("asymmetric pause bit not written");
    pause_bit_a: assert property (adv_wr |=> adv_reg[10] == $past(req.wdata[10])) // see R11
        else $error("pause bit not written");
    tech_flags_a: assert property (adv_wr |=> adv_reg[8:5] == $past(req.wdata[8:5])) // see R12
        else $error("technology flags not written");
    fault_request_a: assert property (adv_wr |=> adv_reg[13] == $past(req.wdata[13])) // see R13
        else $error("remote fault request not written");
    sel_fixed_a: assert property (adv_reg[4:0] == 5'h01 && !adv_reg[14] && !adv_reg[12] && !adv_reg[9]) // see R15
        else $error("advertisement selector or fixed zeros wrong");

    // Without a write the readable register must not drift
    adv_hold_a: assert property (!adv_wr |=> $stable(adv_reg)) // see R9
        else $error("advertisement changed without write");

    // The effective copy takes next_adv of the event cycle, so a write in that same cycle is included
    eff_copy_a: assert property (load_eff |=> adv_effective == $past(next_adv)) // see R23
        else $error("effective advertisement not loaded");

    // Partner word mirrors the received page field by field; bit 15 stays zero
    ack_mirror_a: assert property (page_valid && !sw_reset |=> partner[14] == $past(page_word[14])) // see R16
        else $error("partner acknowledge not mirrored");
    fault_mirror_a: assert property (page_valid && !sw_reset |=> partner[13] == $past(page_word[13])) // see R17
        else $error("partner remote fault not mirrored");
    pause_mirror_a: assert property (page_valid && !sw_reset |=> partner[12:10] == $past(page_word[12:10])) // see R18
        else $error("partner pause bits not mirrored");
    tech_mirror_a: assert property (page_valid && !sw_reset |=> partner[9:5] == $past(page_word[9:5])) // see R19
        else $error("partner technology bits not mirrored");
    selector_mirror_a: assert property ( // see R20
        page_valid && !sw_reset |=> partner[4:0] == $past(page_word[4:0]) && !partner[15])
        else $error("partner selector not mirrored");
    partner_hold_a: assert property (!page_valid && !sw_reset |=> $stable(partner)) // see R20
        else $error("partner ability changed without page");

    // Reading the status word drops each latch back to its live condition; negotiation done follows the engine
    latch_clear_a: assert property (stat_rd && !sw_reset |=> lat_flag == $past(lat_live)) // see R21
        else $error("latched status not returned to live");
    an_follow_a: assert property (!sw_reset |=> an_done == $past(live.an_complete)) // see R2
        else $error("negotiation done not following engine");

    link_drop_c: cover property (link_prev && !live.link_up ##1 $changed(adv_effective));
    page_seen_c: cover property (page_valid ##1 req.rd && sel == PAS_SEL_PARTNER);
    clear_read_c: cover property (lat_flag[2] && stat_rd ##1 !lat_flag[2]);
    adv_load_c: cover property (an_restart ##1 $changed(adv_effective));
    pd_exit_c: cover property (pd_prev && !power_down ##1 $changed(adv_effective));

endmodule // pas_regs

// [tb_phy_autoneg_status_id_regs.sv]
// Self-checking testbench for the autoneg status and identifier register slice
`timescale 1ns/1ps
`include "pas_defines.svh"
module tb_phy_autoneg_status_id_regs
    import pas_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    pas_req_t req;
    logic [15:0] rd_data;
    logic rd_valid;
    pas_live_t live = '0;
    logic sw_reset = 1'b0;
    logic an_restart = 1'b0;
    logic power_down = 1'b0;
    logic page_valid = 1'b0;
    logic [15:0] page_word = 16'h0000;
    logic [5:0] mn = 6'h2A;
    logic [3:0] rn = 4'h5;
    logic [15:0] adv_effective;
    int error_cnt = 0;
    int checks_done = 0;

    // 100 MHz clock
    always #5 ref_clk = ~ref_clk;

    pas_regs i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .req(req), .rd_data(rd_data), .rd_valid(rd_valid),
        .live(live), .sw_reset(sw_reset), .an_restart(an_restart), .power_down(power_down),
        .page_valid(page_valid), .page_word(page_word), .model_number_straps(mn),
        .revision_number_straps(rn), .adv_effective(adv_effective));

    pas_mgmt_model i_mgr (.ref_clk(ref_clk), .req(req), .rd_data(rd_data), .rd_valid(rd_valid));

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rd_chk(input string what, input logic [4:0] a, input logic [15:0] exp);
        logic [15:0] d;
        i_mgr.rd_reg(a, d);
        chk16(what, exp, d);
    endtask

    // One-cycle event: 0 restart, 1 soft reset, 2 power-down exit, 3 link drop, else page
    task automatic fire(input int k);
        @(negedge ref_clk);
        case (k)
            0: an_restart = 1'b1;
            1: sw_reset = 1'b1;
            2: power_down = 1'b1;
            3: live.link_up = 1'b0;
            default: page_valid = 1'b1;
        endcase
        @(negedge ref_clk);
        an_restart = 1'b0;
        sw_reset = 1'b0;
        power_down = 1'b0;
        page_valid = 1'b0;
        live.link_up = (k == 3) ? 1'b1 : live.link_up;
        // Margin for edge detection of power-down and link before loading
        repeat (3) @(negedge ref_clk);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic test_reset();
        rd_chk("status", `PAS_OFF_STATUS, 16'h0049);
        rd_chk("id_high", `PAS_OFF_ID_HIGH, `PAS_OUI_HIGH);
        rd_chk("id_low", `PAS_OFF_ID_LOW, {`PAS_OUI_LOW6, mn, rn});
        rd_chk("advert", `PAS_OFF_ADVERT, 16'h0DE1);
        rd_chk("partner", `PAS_OFF_PARTNER, 16'h0000);
        rd_chk("unmapped", 5'h07, 16'h0000);
        chk16("adv_eff", 16'h0DE1, adv_effective);
        $display("test_reset done");
    endtask

    task automatic test_latch();
        live.remote_fault = 1'b1;
        live.jabber = 1'b1;
        @(negedge ref_clk);
        live.remote_fault = 1'b0;
        live.jabber = 1'b0;
        rd_chk("status_lh", `PAS_OFF_STATUS, 16'h005B);
        rd_chk("status_lh_clr", `PAS_OFF_STATUS, 16'h0049);
        live.link_up = 1'b1;
        rd_chk("status_ll_held", `PAS_OFF_STATUS, 16'h0049);
        rd_chk("status_link", `PAS_OFF_STATUS, 16'h004D);
        i_mgr.wr_reg(`PAS_OFF_STATUS, 16'h0000);
        rd_chk("status_ro", `PAS_OFF_STATUS, 16'h004D);
        fire(3);
        rd_chk("status_ll", `PAS_OFF_STATUS, 16'h0049);
        rd_chk("status_ll_clr", `PAS_OFF_STATUS, 16'h004D);
        $display("test_latch done");
    endtask

    // Each write reads back at once but reaches the transmitter only on an event
    task automatic test_advert();
        logic [15:0] wv [4] = '{16'hFFFF, 16'h0000, 16'h2020, 16'h0DE0};
        logic [15:0] ev [4] = '{16'hADE1, 16'h0001, 16'h2021, 16'h0DE1};
        logic [15:0] prev;
        prev = 16'h0DE1;
        i_mgr.wr_reg(`PAS_OFF_ID_HIGH, 16'h0000);
        rd_chk("id_ro", `PAS_OFF_ID_HIGH, `PAS_OUI_HIGH);
        for (int k = 0; k < 4; k++) begin
            i_mgr.wr_reg(`PAS_OFF_ADVERT, wv[k]);
            rd_chk("adv_readback", `PAS_OFF_ADVERT, ev[k]);
            chk16("adv_held", prev, adv_effective);
            fire(k);
            chk16("adv_loaded", ev[k], adv_effective);
            prev = ev[k];
        end
        $display("test_advert done");
    endtask

    // Partner contents are read only once negotiation shows complete
    task automatic test_partner();
        live.an_complete = 1'b1;
        page_word = 16'hFFFF;
        fire(4);
        rd_chk("status_done", `PAS_OFF_STATUS, 16'h0069);
        rd_chk("partner_all", `PAS_OFF_PARTNER, 16'h7FFF);
        page_word = 16'hA5A5;
        fire(4);
        rd_chk("partner_mix", `PAS_OFF_PARTNER, 16'h25A5);
        // Remote fault is latched before the soft reset so its clear is checked; negotiation stays complete, so the done bit reads one again
        live.remote_fault = 1'b1;
        @(negedge ref_clk);
        live.remote_fault = 1'b0;
        fire(1);
        rd_chk("partner_swrst", `PAS_OFF_PARTNER, 16'h0000);
        rd_chk("status_swrst", `PAS_OFF_STATUS, 16'h0069);
        live.an_complete = 1'b0;
        rd_chk("status_idle", `PAS_OFF_STATUS, 16'h004D);
        $display("test_partner done");
    endtask

    // ************************************************************
    // Sequence, watchdog and verdict
    // ************************************************************
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Reset held 16 cycles; identifier low word needs the strap settle time
    initial begin
        repeat (16) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (6) @(negedge ref_clk);
        test_reset();
        test_latch();
        test_advert();
        test_partner();
        stop_test();
    end

    // Tests take about 125 cycles; forty times that means a hang
    initial begin
        repeat (5000) @(posedge ref_clk);
        error_cnt++;
        $display("[ERR] watchdog expected finish seen hang");
        stop_test();
    end
endmodule // tb_phy_autoneg_status_id_regs
